// >>> logic/ssp_pkg.sv
/*
 * Shared constants, register map, enums and carriers for the soft-start,
 * power-good and switching-clock select block.
 * Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
 */
package ssp_pkg;
	// clock and time base
	localparam int CLK_NS = 50;
	localparam int MS_NS = 1000000;
	localparam int MS_CYC = MS_NS / CLK_NS;
	localparam int SYS_KHZ = MS_CYC;
	localparam int INIT_MS = 2;
	localparam int INIT_CYC = INIT_MS * MS_CYC;
	// clock presence: loss after 3 slowest periods, check window after enable
	localparam int LOSS_NS = 15000;
	localparam int LOSS_CYC = LOSS_NS / CLK_NS;
	localparam int DET_NS = 50000;
	localparam int DET_CYC = DET_NS / CLK_NS;
	localparam logic [2:0] LOCK_EDGES = 3'h4;
	// switching frequency: f = 8 MHz / N
	localparam int BASE_KHZ = 8000;
	localparam int N_MIN = 6;
	localparam int N_MAX = 40;
	localparam int F_LOW_KHZ = 200;
	localparam int F_OPEN_KHZ = 400;
	localparam int F_HIGH_KHZ = 1000;
	localparam logic [5:0] N_LOW = 6'(BASE_KHZ / F_LOW_KHZ);
	localparam logic [5:0] N_OPEN = 6'(BASE_KHZ / F_OPEN_KHZ);
	localparam logic [5:0] N_HIGH = 6'(BASE_KHZ / F_HIGH_KHZ);
	// three-level pin sense encoding, anything else reads as open
	localparam logic [1:0] LVL_LOW = 2'h1;
	localparam logic [1:0] LVL_HIGH = 2'h2;
	// register offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SS_DLY = 8'h04;
	localparam logic [7:0] OFS_SS_RAMP = 8'h08;
	localparam logic [7:0] OFS_PG_DLY = 8'h0C;
	localparam logic [7:0] OFS_PG_WIN = 8'h10;
	localparam logic [7:0] OFS_FREQ = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	// reset values
	localparam logic [15:0] RST_SS_DLY = 16'h0000;
	localparam logic [15:0] RST_SS_RAMP = 16'h000A;
	localparam logic [15:0] RST_PG_DLY = 16'h000A;
	localparam logic [7:0] RST_PG_UNDER = 8'h0A;
	localparam logic [7:0] RST_PG_OVER = 8'h0F;
	localparam logic [15:0] RST_FREQ = 16'h0190;

	typedef enum logic [1:0] {SEQ_OFF, SEQ_START, SEQ_RAMP, SEQ_ON} ssp_seq_e;
	typedef enum logic [1:0] {ROLE_IN, ROLE_AUTO, ROLE_OUT} ssp_role_e;

	typedef struct packed {
		logic freq_sw;
		logic pg_dly_own;
		logic pg_active_low;
		logic seq_sw;
	} ssp_ctrl_s;

	typedef struct packed {
		logic vld;
		logic wr;
		logic [7:0] addr;
	} ssp_aphase_s;

	typedef struct packed {
		logic [1:0] sync_lvl;
		logic [1:0] cfg_lvl;
		logic sync_in;
		logic en;
	} ssp_pins_s;
endpackage : ssp_pkg

// >>> logic/ssp_sync2.sv
/*
 * Two-flop synchroniser for a group of asynchronous level inputs.
 * Assumes each bit is independent; no bus coherence is kept.
 */
`timescale 1ns/100ps
module ssp_sync2 #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : ssp_sync2

// >>> logic/ssp_top.sv
/*
 * Soft-start sequencer, power-good output and switching-clock pin role
 * logic with an AHB-Lite register slave.
 * Assumes strap times already decoded to ms, vout deviation and fault
 * from logic on sys_clk, pin levels asynchronous.
 */
// Operation
// - bus may override strap delay and ramp
// - zero delay ramps right after 2 ms init
// - zero ramp means no controlled ramp
// - power good only fault-free and inside window
// - window limits and polarity are programmable
// - power good waits delay after conditions met
// - default power-good delay equals ramp time
// - power-good delay programmable independently
// - role pin selects input, auto or output
// - output role drives internal 400 kHz oscillator
// - output role never samples the clock pin
// - input role checks clock each enable, locks
// - lost clock falls back near previous frequency
// - auto role synchronises to a present clock
// - auto without clock picks frequency from pin
// - bus frequency rounded to 8 MHz over N
`timescale 1ns/100ps
module ssp_top import ssp_pkg::*; #(
	parameter int MS_CYC_P = MS_CYC,
	parameter int INIT_CYC_P = INIT_CYC
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic en_pin,
	input wire logic [1:0] cfg_lvl,
	input wire logic [1:0] sync_lvl,
	input wire logic sync_in,
	output logic sync_out,
	output logic sync_oe,
	input wire logic [15:0] start_delay_strap,
	input wire logic [15:0] ramp_strap,
	input wire logic fault,
	input wire logic signed [7:0] vout_dev_pct,
	output logic conv_run,
	output logic soft_ramp,
	output logic output_in_tolerance_flag,
	output logic [5:0] fsw_n,
	output logic ext_clk_used
);
	////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [5:0] n_from_khz(input logic [15:0] khz);
		int q;
		q = N_MAX;
		if (khz != 16'h0000)
			q = (BASE_KHZ + int'(khz) / 2) / int'(khz);
		if (q < N_MIN)
			q = N_MIN;
		if (q > N_MAX)
			q = N_MAX;
		return 6'(q);
	endfunction : n_from_khz

	function automatic logic [8:0] half_of(input logic [5:0] n);
		return 9'((int'(n) * SYS_KHZ) / (2 * BASE_KHZ));
	endfunction : half_of

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	ssp_pins_s pins_s;
	ssp_sync2 #(.W($bits(ssp_pins_s))) u_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.d({sync_lvl, cfg_lvl, sync_in, en_pin}),
		.q(pins_s)
	);

	////////////////////////////////////////////////////////////////////////
	// register bus
	ssp_aphase_s ap;
	ssp_ctrl_s ctrl;
	logic [15:0] reg_dly;
	logic [15:0] reg_ramp;
	logic [15:0] reg_pgd;
	logic [7:0] reg_under;
	logic [7:0] reg_over;
	logic [15:0] reg_freq;
	logic [31:0] status;
	logic [31:0] rd_mux;
	logic bus_wr;

	assign bus_wr = ap.vld && ap.wr && hready;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ap <= '0;
		end else if (hready) begin
			ap.vld <= hsel && htrans[1];
			ap.wr <= hwrite;
			ap.addr <= haddr[7:0];
		end
	end

	// reads take one wait state so a just-written value is seen
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			hreadyout <= 1'b1;
			hrdata <= '0;
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
			hreadyout <= !(hready && hsel && htrans[1] && !hwrite);
			if (ap.vld && !ap.wr && !hreadyout)
				hrdata <= rd_mux;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= '0;
			reg_dly <= RST_SS_DLY;
			reg_ramp <= RST_SS_RAMP;
			reg_pgd <= RST_PG_DLY;
			reg_under <= RST_PG_UNDER;
			reg_over <= RST_PG_OVER;
			reg_freq <= RST_FREQ;
		end else if (bus_wr) begin
			unique case (ap.addr)
				OFS_CTRL: ctrl <= hwdata[$bits(ssp_ctrl_s)-1:0];
				OFS_SS_DLY: reg_dly <= hwdata[15:0];
				OFS_SS_RAMP: reg_ramp <= hwdata[15:0];
				OFS_PG_DLY: reg_pgd <= hwdata[15:0];
				OFS_PG_WIN: begin
					reg_under <= hwdata[7:0];
					reg_over <= hwdata[15:8];
				end
				OFS_FREQ: reg_freq <= hwdata[15:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		unique case (ap.addr)
			OFS_CTRL: rd_mux = 32'(ctrl);
			OFS_SS_DLY: rd_mux = 32'(reg_dly);
			OFS_SS_RAMP: rd_mux = 32'(reg_ramp);
			OFS_PG_DLY: rd_mux = 32'(reg_pgd);
			OFS_PG_WIN: rd_mux = {16'h0000, reg_over, reg_under};
			OFS_FREQ: rd_mux = 32'(reg_freq);
			OFS_STATUS: rd_mux = status;
			default: rd_mux = 32'h00000000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// soft-start sequencer
	ssp_seq_e state;
	ssp_seq_e next_state;
	logic [15:0] dly_ms;
	logic [15:0] ramp_ms;
	logic [15:0] seq_ms;
	logic [31:0] seq_tick;
	logic [31:0] init_cnt;
	logic init_done;

	assign dly_ms = ctrl.seq_sw ? reg_dly : start_delay_strap;
	assign ramp_ms = ctrl.seq_sw ? reg_ramp : ramp_strap;
	assign init_done = init_cnt >= 32'(INIT_CYC_P);

	always_comb begin
		next_state = state;
		if (!pins_s.en) begin
			next_state = SEQ_OFF;
		end else begin
			unique case (state)
				SEQ_OFF: next_state = SEQ_START;
				SEQ_START: begin
					if (init_done && seq_ms >= dly_ms)
						next_state = (ramp_ms == 16'h0000) ? SEQ_ON : SEQ_RAMP;
				end
				SEQ_RAMP: begin
					if (seq_ms >= ramp_ms)
						next_state = SEQ_ON;
				end
				SEQ_ON: next_state = SEQ_ON;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			state <= SEQ_OFF;
		else
			state <= next_state;
	end

	// ms counter restarts on every state change
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			seq_tick <= '0;
			seq_ms <= '0;
		end else if (next_state != state) begin
			seq_tick <= '0;
			seq_ms <= '0;
		end else if (seq_tick == 32'(MS_CYC_P - 1)) begin
			seq_tick <= '0;
			if (seq_ms != 16'hFFFF)
				seq_ms <= seq_ms + 16'h0001;
		end else begin
			seq_tick <= seq_tick + 32'h00000001;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			init_cnt <= '0;
		else if (state == SEQ_OFF)
			init_cnt <= '0;
		else if (!init_done)
			init_cnt <= init_cnt + 32'h00000001;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			conv_run <= 1'b0;
			soft_ramp <= 1'b0;
		end else begin
			conv_run <= next_state == SEQ_RAMP || next_state == SEQ_ON;
			soft_ramp <= next_state == SEQ_RAMP;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// power good
	logic signed [8:0] dev9;
	logic pg_cond;
	logic [15:0] pgd_ms;
	logic [15:0] pg_ms;
	logic [31:0] pg_tick;

	assign dev9 = 9'(vout_dev_pct);
	assign pg_cond = state == SEQ_ON && !fault
		&& dev9 >= -$signed({1'b0, reg_under})
		&& dev9 <= $signed({1'b0, reg_over});
	assign pgd_ms = ctrl.pg_dly_own ? reg_pgd : ramp_ms;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pg_tick <= '0;
			pg_ms <= '0;
		end else if (!pg_cond) begin
			pg_tick <= '0;
			pg_ms <= '0;
		end else if (pg_tick == 32'(MS_CYC_P - 1)) begin
			pg_tick <= '0;
			if (pg_ms != 16'hFFFF)
				pg_ms <= pg_ms + 16'h0001;
		end else begin
			pg_tick <= pg_tick + 32'h00000001;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			output_in_tolerance_flag <= 1'b0;
		else
			output_in_tolerance_flag <= (pg_cond && pg_ms >= pgd_ms) ^ ctrl.pg_active_low;
	end

	////////////////////////////////////////////////////////////////////////
	// clock role and presence detection
	ssp_role_e role;
	logic en_d;
	logic en_rise;
	logic sync_d;
	logic clk_rise;
	logic [8:0] gap;
	logic [8:0] per_meas;
	logic [2:0] edges;
	logic present;
	logic [9:0] det_cnt;
	logic checking;
	logic hold;
	logic [5:0] auto_n;

	assign en_rise = pins_s.en && !en_d;
	assign clk_rise = role != ROLE_OUT && pins_s.sync_in && !sync_d;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			en_d <= 1'b0;
			sync_d <= 1'b0;
			role <= ROLE_IN;
		end else begin
			en_d <= pins_s.en;
			sync_d <= pins_s.sync_in;
			if (en_rise) begin
				unique case (pins_s.cfg_lvl)
					LVL_LOW: role <= ROLE_IN;
					LVL_HIGH: role <= ROLE_OUT;
					default: role <= ROLE_AUTO;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			gap <= '0;
			per_meas <= '0;
			edges <= '0;
			present <= 1'b0;
		end else if (role == ROLE_OUT) begin
			gap <= '0;
			edges <= '0;
			present <= 1'b0;
		end else if (clk_rise) begin
			gap <= '0;
			per_meas <= gap + 9'h001;
			if (edges != LOCK_EDGES)
				edges <= edges + 3'h1;
			else
				present <= 1'b1;
		end else if (gap == 9'(LOSS_CYC)) begin
			edges <= '0;
			present <= 1'b0;
		end else begin
			gap <= gap + 9'h001;
		end
	end

	// check window after each enable outside output role, then latch the source
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			det_cnt <= '0;
			checking <= 1'b0;
			ext_clk_used <= 1'b0;
			hold <= 1'b0;
			auto_n <= N_OPEN;
		end else if (en_rise) begin
			det_cnt <= '0;
			checking <= 1'b1;
			ext_clk_used <= 1'b0;
			hold <= 1'b0;
		end else if (checking && role == ROLE_OUT) begin
			checking <= 1'b0;
		end else if (checking) begin
			det_cnt <= det_cnt + 10'h001;
			if (det_cnt == 10'(DET_CYC - 1)) begin
				checking <= 1'b0;
				ext_clk_used <= present;
				unique case (pins_s.sync_lvl)
					LVL_LOW: auto_n <= N_LOW;
					LVL_HIGH: auto_n <= N_HIGH;
					default: auto_n <= N_OPEN;
				endcase
			end
		end else if (ext_clk_used && !present) begin
			ext_clk_used <= 1'b0;
			hold <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// internal oscillator and frequency choice
	logic [5:0] int_n;
	logic [8:0] half;
	logic [8:0] osc_cnt;
	logic osc;

	always_comb begin
		if (role == ROLE_OUT)
			int_n = N_OPEN;
		else if (ctrl.freq_sw)
			int_n = n_from_khz(reg_freq);
		else if (role == ROLE_AUTO)
			int_n = auto_n;
		else
			int_n = N_OPEN;
		half = (ext_clk_used || hold) ? {1'b0, per_meas[8:1]} : half_of(int_n);
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			osc <= 1'b0;
			osc_cnt <= '0;
		end else if (ext_clk_used && clk_rise) begin
			osc <= 1'b1;
			osc_cnt <= '0;
		end else if (osc_cnt >= half - 9'h001) begin
			osc <= !osc;
			osc_cnt <= '0;
		end else begin
			osc_cnt <= osc_cnt + 9'h001;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sync_out <= 1'b0;
			sync_oe <= 1'b0;
			fsw_n <= N_OPEN;
		end else begin
			sync_out <= osc;
			sync_oe <= role == ROLE_OUT;
			fsw_n <= int_n;
		end
	end

	assign status = {16'h0000, 2'h0, fsw_n, role, ext_clk_used, present, pg_cond,
		hold, state};

	logic unused_ok;
	assign unused_ok = &{1'b0, haddr[31:8], hsize};
endmodule : ssp_top

// >>> testbench/ssp_clk_src.sv
/*
 * external clock source on the shared clock pin
 * assumes the bench gates it with run; idle level low
 */
`timescale 1ns/100ps
module ssp_clk_src #(
	parameter int HALF_NS = 200
) (
	input wire logic run,
	output logic clk
);
initial begin
	clk = 1'b0;
	forever begin
		#(HALF_NS);
		clk = run ? !clk : 1'b0;
	end
end
endmodule : ssp_clk_src

// >>> testbench/ssp_properties.sv
/*
 * port checker for ssp_top
 * assumes it is bound into ssp_top by the bench
 */
`timescale 1ns/100ps
module ssp_properties import ssp_pkg::*; (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic en_pin,
	input wire logic fault,
	input wire logic sync_oe,
	input wire logic conv_run,
	input wire logic soft_ramp,
	input wire logic output_in_tolerance_flag,
	input wire logic [5:0] fsw_n,
	input wire logic ext_clk_used
);
default clocking @(posedge sys_clk); endclocking
default disable iff (!nrst);
////////////////////////////////////////////////////////////////
sequence s_take(w);
	hsel && hready && htrans[1] && (hwrite == w);
endsequence
sequence s_rd_wait;
	!hreadyout ##1 hreadyout;
endsequence
a_read_wait: assert property (s_take(1'b0) |=> s_rd_wait) else $error("read wait wrong");
a_write_nowait: assert property (s_take(1'b1) |=> hreadyout) else $error("write stalled");
a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
a_ramp_in_run: assert property (soft_ramp |-> conv_run) else $error("ramp outside run");
a_run_after_en: assert property ($rose(conv_run) |-> $past(en_pin, 3))
	else $error("run without enable");
a_off_no_en: assert property (!en_pin [*5] |-> !conv_run) else $error("run after enable low");
a_flag_fault: assert property (fault [*3] |-> $stable(output_in_tolerance_flag))
	else $error("flag moved in fault");
a_fsw_range: assert property (fsw_n >= 6'h06 && fsw_n <= 6'h28)
	else $error("divider out of range");
a_out_no_ext: assert property (sync_oe |-> !ext_clk_used) else $error("output role locked");
endmodule : ssp_properties

// >>> testbench/tb_ssp_top.sv
/*
 * bench for ssp_top: AHB-Lite tasks, sequencer, power good, clock roles
 * assumes scaled ms (20 cycles) and init (40 cycles)
 */
`timescale 1ns/100ps
module tb_ssp_top import ssp_pkg::*; ;
logic sys_clk, nrst, hsel, hwrite, en_pin, fault, run, ext_clk, sync_in, rs;
logic hready, hreadyout, hresp, sync_out, sync_oe, conv_run, soft_ramp, flag, ext, p;
logic [31:0] haddr, hwdata, hrdata, q;
logic [1:0] htrans, cfg_lvl, sync_lvl;
logic [2:0] hsize;
logic [15:0] sd_strap, rp_strap;
logic signed [7:0] dev;
logic [5:0] fsw_n;
logic [31:0] rv [7];
int failures, samples_checked, cyc, n, c;
assign hready = hreadyout;
assign sync_in = sync_oe ? sync_out : ext_clk;
ssp_clk_src #(.HALF_NS(200)) i_src (.run(run), .clk(ext_clk));
ssp_top #(.MS_CYC_P(20), .INIT_CYC_P(40)) i_dut (.sys_clk(sys_clk), .nrst(nrst),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .en_pin(en_pin), .cfg_lvl(cfg_lvl), .sync_lvl(sync_lvl),
	.sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe),
	.start_delay_strap(sd_strap), .ramp_strap(rp_strap), .fault(fault),
	.vout_dev_pct(dev), .conv_run(conv_run), .soft_ramp(soft_ramp),
	.output_in_tolerance_flag(flag), .fsw_n(fsw_n), .ext_clk_used(ext));
////////////////////////////////////////////////////////////////
initial begin
	sys_clk = 1'b0;
	forever #25 sys_clk = ~sys_clk;
end
always @(negedge sys_clk) if (soft_ramp === 1'b1) rs = 1'b1;
always @(posedge sys_clk) begin
	cyc++;
	if (cyc == 40000) begin
		failures++;
		$display("Error %0t: timeout", $time);
		results();
	end
end
////////////////////////////////////////////////////////////////
task results;
	$display("checks %0d failures %0d", samples_checked, failures);
	if (failures == 0 && samples_checked > 0) $display("All tests passed");
	else $display("Some tests failed");
	$finish;
endtask : results
task chk(input logic [31:0] g, input logic [31:0] e);
	samples_checked++;
	if (g !== e) begin
		failures++;
		$display("Error %0t: got %h expected %h", $time, g, e);
	end
endtask : chk
task chkr(input int g, input int lo, input int hi);
	samples_checked++;
	if (g < lo || g > hi) begin
		failures++;
		$display("Error %0t: count %0d not in %0d..%0d", $time, g, lo, hi);
	end
endtask : chkr
task wt(input int k);
	repeat (k) @(posedge sys_clk);
endtask : wt
task rdy;
	int m;
	m = 0;
	do begin
		@(negedge sys_clk);
		m++;
	end while (hreadyout !== 1'b1 && m < 50);
	if (hreadyout !== 1'b1) begin
		failures++;
		$display("Error %0t: bus wait limit", $time);
	end
	@(posedge sys_clk);
endtask : rdy
task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
	@(posedge sys_clk);
	hsel <= 1'b1;
	haddr <= {24'h000000, a};
	htrans <= 2'h2;
	hwrite <= w;
	rdy();
	hsel <= 1'b0;
	htrans <= 2'h0;
	hwdata <= d;
	rdy();
	q = hrdata;
endtask : xf
function logic sel(input int k);
	case (k)
		0: sel = conv_run;
		1: sel = soft_ramp;
		2: sel = flag;
		default: sel = ext;
	endcase
endfunction : sel
task ws(input int k, input logic v);
	n = 0;
	while (sel(k) !== v && n < 4000) begin
		@(negedge sys_clk);
		n++;
	end
	if (sel(k) !== v) begin
		failures++;
		$display("Error %0t: wait limit", $time);
	end
	@(posedge sys_clk);
endtask : ws
task tg;
	c = 0;
	p = sync_out;
	repeat (500) begin
		@(negedge sys_clk);
		if (sync_out !== p) c++;
		p = sync_out;
	end
endtask : tg
task rl(input int k);
	en_pin <= 1'b0;
	wt(6);
	en_pin <= 1'b1;
	wt(k);
	@(negedge sys_clk);
endtask : rl
////////////////////////////////////////////////////////////////
initial begin
	{nrst, hsel, hwrite, en_pin, fault, run, rs} = '0;
	{haddr, hwdata, htrans, sync_lvl, dev, sd_strap} = '0;
	hsize = 3'h2;
	cfg_lvl = 2'h1;
	rp_strap = 16'h0003;
	rv = '{32'h0, 32'(RST_SS_DLY), 32'(RST_SS_RAMP), 32'(RST_PG_DLY),
		{16'h0, RST_PG_OVER, RST_PG_UNDER}, 32'(RST_FREQ), 32'h0};
	wt(12);
	nrst <= 1'b1;
	xf(1'b1, 8'h1C, 32'hFFFFFFFF);
	for (int i = 0; i < 7; i++) begin
		xf(1'b0, (i == 6) ? 8'h1C : 8'(4 * i), 32'h0);
		chk(q, rv[i]);
	end
	$display("registers done");
	en_pin <= 1'b1;
	ws(0, 1'b1);
	chkr(n, 40, 46);
	ws(1, 1'b0);
	chkr(n, 56, 62);
	ws(2, 1'b1);
	chkr(n, 56, 63);
	chk(fsw_n, 6'h14);
	for (int i = 0; i < 5; i++) begin
		dev <= (i == 0) ? -8'sd10 : (i == 1) ? 8'sd15 : (i == 2) ? -8'sd11 : (i == 3) ? 8'sd16 : 8'sd0;
		fault <= (i == 4);
		wt(1);
		@(negedge sys_clk);
		chk(flag, i < 2);
		@(posedge sys_clk);
		dev <= 8'sd0;
		fault <= 1'b0;
		ws(2, 1'b1);
	end
	xf(1'b1, OFS_PG_WIN, 32'h0F05);
	dev <= -8'sd6;
	wt(3);
	@(negedge sys_clk);
	chk(flag, 1'b0);
	xf(1'b1, OFS_CTRL, 32'h2);
	wt(2);
	@(negedge sys_clk);
	chk(flag, 1'b1);
	$display("power good done");
	@(posedge sys_clk);
	en_pin <= 1'b0;
	ws(0, 1'b0);
	chkr(n, 2, 5);
	xf(1'b1, OFS_CTRL, 32'h5);
	xf(1'b1, OFS_SS_DLY, 32'h5);
	xf(1'b1, OFS_SS_RAMP, 32'h0);
	xf(1'b1, OFS_PG_DLY, 32'h1);
	xf(1'b1, OFS_PG_WIN, 32'h0F0A);
	dev <= 8'sd0;
	en_pin <= 1'b1;
	rs = 1'b0;
	ws(0, 1'b1);
	chkr(n, 100, 106);
	ws(2, 1'b1);
	chkr(n, 19, 23);
	chk(rs, 1'b0);
	$display("override done");
	xf(1'b1, OFS_CTRL, 32'h8);
	for (int i = 0; i < 4; i++) begin
		xf(1'b1, OFS_FREQ, (i == 0) ? 810 : (i == 1) ? 100 : (i == 2) ? 2000 : 400);
		rl(1100);
		chk(fsw_n, (i == 0) ? 10 : (i == 1) ? 40 : (i == 2) ? 6 : 20);
	end
	$display("frequency done");
	xf(1'b1, OFS_CTRL, 32'h0);
	cfg_lvl <= 2'h2;
	run <= 1'b1;
	rl(1100);
	chk(sync_oe, 1'b1);
	chk(ext, 1'b0);
	tg();
	chkr(c, 19, 21);
	@(posedge sys_clk);
	cfg_lvl <= 2'h1;
	rl(1100);
	chk(ext, 1'b1);
	@(posedge sys_clk);
	run <= 1'b0;
	ws(3, 1'b0);
	chkr(n, 290, 320);
	xf(1'b0, OFS_STATUS, 32'h0);
	chk(q[2], 1'b1);
	tg();
	chkr(c, 124, 126);
	@(posedge sys_clk);
	cfg_lvl <= 2'h0;
	for (int i = 0; i < 3; i++) begin
		sync_lvl <= 2'(i == 0 ? 1 : i == 1 ? 2 : 0);
		rl(1100);
		chk(fsw_n, (i == 0) ? 40 : (i == 1) ? 8 : 20);
		@(posedge sys_clk);
	end
	run <= 1'b1;
	rl(1100);
	chk(ext, 1'b1);
	$display("clock roles done");
	results();
end
endmodule : tb_ssp_top
bind ssp_top ssp_properties u_props (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .en_pin(en_pin), .fault(fault), .sync_oe(sync_oe),
	.conv_run(conv_run), .soft_ramp(soft_ramp), .fsw_n(fsw_n),
	.output_in_tolerance_flag(output_in_tolerance_flag), .ext_clk_used(ext_clk_used));
